// ### core/mpi_core.sv
// module: program counter, machine cycle sequencer, strobes and ports
`timescale 1ns/10ps
`default_nettype none
module mpi_core #(
  parameter int ROM_BYTES = 1024,
  parameter int RAM_BYTES = 64
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_op_valid,
  input  wire mpi_pkg::mpi_op_t i_op,
  input  wire logic             i_op_first,
  input  wire logic [11:0]      i_op_addr,
  input  wire logic [7:0]       i_op_data,
  input  wire logic [2:0]       i_op_reg,
  output logic                  o_op_ready,
  output logic [7:0]            o_rdata,
  output logic                  o_rdata_valid,
  output logic [11:0]           o_pc,
  output logic                  o_irq_taken,
  output logic [11:0]           o_rom_addr,
  input  wire logic [7:0]       i_rom_data,
  input  wire logic             i_timer_ovf,
  output logic                  o_count_pulse,
  output logic                  o_count_en,
  output logic                  o_test_zero,
  output logic                  o_test_one,
  output logic                  o_irq_pin_low,
  output logic                  o_bank1,
  output logic                  o_halted,
  input  wire logic             i_int_n,
  input  wire logic             i_ss_n,
  input  wire logic             i_ea,
  input  wire logic             i_t0,
  output logic                  o_t0,
  output logic                  o_t0_oe_n,
  input  wire logic             i_t1,
  input  wire logic [7:0]       i_bus,
  output logic [7:0]            o_bus,
  output logic                  o_bus_oe_n,
  output logic                  o_ale,
  output logic                  o_rd_n,
  output logic                  o_wr_n,
  output logic                  o_fetch_strobe_n,
  output logic                  o_expander_strobe,
  input  wire logic [7:0]       i_port_one,
  output logic [7:0]            o_port_one,
  output logic [7:0]            o_port_one_oe_n,
  input  wire logic [7:0]       i_port_two,
  output logic [7:0]            o_port_two,
  output logic [7:0]            o_port_two_oe_n
);
  import mpi_pkg::*;

  function automatic logic [7:0] reg_addr(input logic b, input logic [2:0] r);
    reg_addr = (b ? BANK1_BASE : BANK0_BASE) + {5'h0, r};
  endfunction : reg_addr

  function automatic logic [7:0] stk_addr(input logic [2:0] s, input logic h);
    stk_addr = STACK_BASE + {4'h0, s, h};
  endfunction : stk_addr

  logic [SYNC_W-1:0] sy;
  mpi_ram_if         ram ();
  mpi_phase_t        phase;
  mpi_op_t           op_q;
  logic [PC_W-1:0]   pc;
  logic [11:0]       addr_q;
  logic [7:0]        data_q, ptr_q, ret_lo, p1_lat, p2_lat;
  logic [2:0]        reg_q, sp;
  logic [3:0]        p2o_val;
  logic              ext_q, ext_sel, ready, hold, irq_go, irq_ext, irq_tmr;
  logic              ext_en, tmr_en, tmr_pend, in_service, clk_out_en;
  logic              t1_d, p2o_en, fetched;
  logic              ss_low, int_low, ea_hi;

  mpi_sync #(.W(SYNC_W), .RST(SYNC_RST)) u_sync (
    .i_clk     (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_d       ({i_int_n, i_ss_n, i_ea, i_t0, i_t1, i_bus,
                 i_port_one, i_port_two}),
    .o_q       (sy)
  );

  mpi_ram #(.DEPTH(RAM_BYTES)) u_ram (
    .i_clk (i_sys_clk),
    .bus   (ram.ram)
  );

  assign ss_low  = !sy[SY_SS];
  assign int_low = !sy[SY_INT];
  assign ea_hi   = sy[SY_EA];
  assign ext_sel = ea_hi || int'(pc) >= ROM_BYTES; // RULE_05 RULE_07

  ////////////////////////////////////////////////////////////////////////////
  // request hand-shake, single step and interrupt acceptance

  assign hold    = ss_low && i_op_valid && i_op_first; // RULE_16
  assign ready   = phase == PH_6 && !hold;
  assign irq_ext = int_low && ext_en && !in_service; // RULE_02
  assign irq_tmr = tmr_pend && !in_service;
  assign irq_go  = ready && i_op_valid && i_op_first && (irq_ext || irq_tmr);

  assign o_op_ready = ready;
  assign o_halted   = phase == PH_HALT;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase <= PH_6;
    end else begin
      unique case (phase)
        PH_1:    phase <= PH_2;
        PH_2:    phase <= PH_3;
        PH_3:    phase <= PH_4;
        PH_4:    phase <= PH_5;
        PH_5:    phase <= PH_6;
        PH_6:    phase <= ready ? PH_1 : PH_HALT; // RULE_16
        PH_HALT: phase <= ss_low ? PH_HALT : PH_6; // RULE_16
        default: phase <= PH_6;
      endcase
    end
  end

  // the interrupt replaces the offered first byte; the caller re-offers it
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      op_q   <= OP_NONE;
      addr_q <= RESET_VEC;
      data_q <= 8'h00;
      reg_q  <= 3'h0;
    end else if (ready) begin
      op_q   <= !i_op_valid ? OP_NONE : (irq_go ? OP_CALL : i_op);
      addr_q <= !irq_go ? i_op_addr :
                (irq_ext ? EXT_IRQ_VEC : TMR_IRQ_VEC); // RULE_03 RULE_04
      data_q <= i_op_data;
      reg_q  <= i_op_reg;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ptr_q  <= 8'h00;
      ext_q  <= 1'b0;
      ret_lo <= 8'h00;
    end else begin
      if (phase == PH_1) begin
        ptr_q <= ram.rdata; // RULE_19
        ext_q <= ext_sel;
      end
      if (phase == PH_2) begin
        ret_lo <= ram.rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // resident RAM addressing: pointers, register banks and stack

  always_comb begin
    ram.addr  = reg_addr(o_bank1, {2'h0, reg_q[0]}); // RULE_19
    ram.wdata = data_q;
    ram.we    = 1'b0;
    if (phase != PH_1 && phase != PH_HALT) begin
      unique case (op_q)
        OP_REG_RD, OP_REG_WR: begin
          ram.addr = reg_addr(o_bank1, reg_q); // RULE_20
          ram.we   = op_q == OP_REG_WR && phase == PH_4;
        end
        OP_IND_RD, OP_IND_WR: begin
          ram.addr = ptr_q; // RULE_19
          ram.we   = op_q == OP_IND_WR && phase == PH_4;
        end
        OP_CALL: begin
          ram.addr  = stk_addr(sp, phase == PH_3); // RULE_21
          ram.wdata = phase == PH_3 ? {4'h0, pc[11:8]} : pc[7:0];
          ram.we    = phase == PH_2 || phase == PH_3;
        end
        OP_RET, OP_RETR: begin
          ram.addr = stk_addr(sp - 3'h1, phase != PH_2); // RULE_21
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter and stack pointer

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pc <= RESET_VEC; // RULE_01
      sp <= 3'h0;
    end else if (phase == PH_6) begin
      unique case (op_q)
        OP_FETCH: pc <= pc + 12'h001; // RULE_06 RULE_08
        OP_JUMP:  pc <= addr_q; // RULE_08
        OP_CALL: begin
          pc <= addr_q;
          sp <= sp + 3'h1; // RULE_23
        end
        OP_RET, OP_RETR: begin
          pc <= {ram.rdata[3:0], ret_lo};
          sp <= sp - 3'h1;
        end
        default: ;
      endcase
    end
  end

  assign o_pc       = pc;
  assign o_rom_addr = pc;

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata       <= 8'h00;
      o_rdata_valid <= 1'b0;
      o_irq_taken   <= 1'b0;
    end else begin
      o_rdata_valid <= 1'b0;
      o_irq_taken   <= irq_go;
      if (phase == PH_6) begin
        o_rdata_valid <= 1'b1;
        unique case (op_q)
          OP_FETCH:             o_rdata <= ext_q ? sy[SY_BUS +: 8]
                                                 : i_rom_data; // RULE_09
          OP_XRD, OP_BRD:       o_rdata <= sy[SY_BUS +: 8]; // RULE_13
          OP_REG_RD, OP_IND_RD: o_rdata <= ram.rdata;
          OP_P1RD:              o_rdata <= sy[SY_P1 +: 8]; // RULE_22
          OP_P2RD:              o_rdata <= sy[SY_P2 +: 8]; // RULE_22
          OP_EXP_RD:            o_rdata <= {4'h0, sy[SY_P2 +: 4]};
          default:              o_rdata_valid <= 1'b0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode flags, interrupt enables and timer pending

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_bank1    <= 1'b0;
      ext_en     <= 1'b0; // RULE_02
      tmr_en     <= 1'b0;
      clk_out_en <= 1'b0;
      o_count_en <= 1'b0;
      in_service <= 1'b0;
    end else begin
      if (phase == PH_6) begin
        unique case (op_q)
          OP_SEL_RB0:   o_bank1    <= 1'b0; // RULE_20
          OP_SEL_RB1:   o_bank1    <= 1'b1; // RULE_20
          OP_EN_IRQ:    ext_en     <= 1'b1;
          OP_DIS_IRQ:   ext_en     <= 1'b0;
          OP_EN_TIRQ:   tmr_en     <= 1'b1;
          OP_DIS_TIRQ:  tmr_en     <= 1'b0;
          OP_CLK_OUT:   clk_out_en <= 1'b1; // RULE_17
          OP_START_CNT: o_count_en <= 1'b1; // RULE_18
          OP_STOP_CNT:  o_count_en <= 1'b0;
          OP_RETR:      in_service <= 1'b0;
          default: ;
        endcase
      end
      if (irq_go) begin
        in_service <= 1'b1;
      end
    end
  end

  // an overflow in the very cycle the pending bit is consumed is kept
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tmr_pend <= 1'b0;
    end else if (i_timer_ovf && tmr_en) begin
      tmr_pend <= 1'b1; // RULE_04
    end else if (irq_go && !irq_ext) begin
      tmr_pend <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // test pins: clock output and event count source

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_t0          <= 1'b0;
      t1_d          <= 1'b0;
      o_count_pulse <= 1'b0;
    end else begin
      o_t0          <= clk_out_en && !o_t0; // RULE_17
      t1_d          <= sy[SY_T1];
      o_count_pulse <= o_count_en && t1_d && !sy[SY_T1]; // RULE_18
    end
  end

  assign o_t0_oe_n     = !clk_out_en;
  assign o_test_zero   = sy[SY_T0]; // RULE_17
  assign o_test_one    = sy[SY_T1]; // RULE_18
  assign o_irq_pin_low = int_low;

  ////////////////////////////////////////////////////////////////////////////
  // bus strobes: address in phase 2 under the latch pulse, read and fetch strobes 4 to 6, write 4 to 5, expander 2 to 3

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_ale             <= 1'b0;
      o_rd_n            <= 1'b1;
      o_wr_n            <= 1'b1;
      o_fetch_strobe_n  <= 1'b1;
      o_expander_strobe <= 1'b0;
      o_bus             <= 8'h00;
      o_bus_oe_n        <= 1'b1;
      p2o_en            <= 1'b0;
      p2o_val           <= 4'h0;
    end else begin
      unique case (phase)
        PH_1: begin
          o_ale <= 1'b1; // RULE_12
          if (op_q == OP_FETCH && ext_sel) begin
            o_bus      <= pc[7:0]; // RULE_09
            o_bus_oe_n <= 1'b0;
            p2o_en     <= 1'b1;
            p2o_val    <= pc[11:8]; // RULE_10
          end else if (op_q == OP_XRD || op_q == OP_XWR) begin
            o_bus      <= ptr_q; // RULE_15
            o_bus_oe_n <= 1'b0;
          end else if (op_q == OP_EXP_RD || op_q == OP_EXP_WR) begin
            p2o_en            <= 1'b1;
            p2o_val           <= data_q[3:0]; // RULE_22
            o_expander_strobe <= 1'b1; // RULE_22
          end
        end
        PH_2: o_ale <= 1'b0; // RULE_12
        PH_3: begin
          o_bus_oe_n        <= 1'b1;
          o_expander_strobe <= 1'b0;
          unique case (op_q)
            OP_FETCH:       o_fetch_strobe_n <= !ext_q; // RULE_11
            OP_XRD, OP_BRD: o_rd_n <= 1'b0; // RULE_13
            OP_XWR, OP_BWR: begin
              o_wr_n     <= 1'b0; // RULE_14
              o_bus      <= data_q; // RULE_15
              o_bus_oe_n <= 1'b0;
            end
            OP_EXP_WR: p2o_val <= data_q[7:4];
            OP_EXP_RD: p2o_en  <= 1'b0;
            default: ;
          endcase
        end
        // write strobe rises a phase before the data is withdrawn
        PH_5: o_wr_n <= 1'b1;
        PH_6: begin
          o_rd_n           <= 1'b1;
          o_fetch_strobe_n <= 1'b1;
          o_bus_oe_n       <= 1'b1;
          p2o_en           <= 1'b0;
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // quasi-bidirectional ports: a 1 is released so the pin can be read

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      p1_lat <= PORT_RST;
      p2_lat <= PORT_RST;
    end else if (phase == PH_6) begin
      if (op_q == OP_P1WR) begin
        p1_lat <= data_q; // RULE_22
      end
      if (op_q == OP_P2WR) begin
        p2_lat <= data_q; // RULE_22
      end
    end
  end

  assign o_port_one      = p1_lat;
  assign o_port_one_oe_n = p1_lat; // RULE_22
  assign o_port_two      = {p2_lat[7:4], p2o_en ? p2o_val : p2_lat[3:0]};
  assign o_port_two_oe_n = {p2_lat[7:4], p2o_en ? 4'h0 : p2_lat[3:0]};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fetched <= 1'b0;
    end else if (phase == PH_6 && op_q != OP_NONE) begin
      fetched <= 1'b1;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  reset_vector_a: assert property (!fetched |-> pc == RESET_VEC) // RULE_01
    else $error("counter left zero before first operation");
  irq_gate_a: assert property (irq_go && irq_ext |-> ext_en && int_low) // RULE_02
    else $error("external interrupt taken while disabled");
  ext_vector_a: assert property (irq_go && irq_ext |-> ##7 pc == EXT_IRQ_VEC) // RULE_03
    else $error("external interrupt did not reach its vector");
  tmr_vector_a: assert property (irq_go && !irq_ext |-> ##7 pc == TMR_IRQ_VEC) // RULE_04
    else $error("timer interrupt did not reach its vector");
  ea_fetch_a: assert property (phase == PH_1 && op_q == OP_FETCH && ea_hi // RULE_05
    |-> ##3 !o_fetch_strobe_n) else $error("fetch not external with access high");
  rom_edge_a: assert property (phase == PH_1 && op_q == OP_FETCH // RULE_07
    && int'(pc) >= ROM_BYTES |-> ##3 !o_fetch_strobe_n)
    else $error("fetch beyond ROM stayed internal");
  pc_step_a: assert property (phase == PH_6 && op_q == OP_FETCH // RULE_08
    |=> pc == $past(pc) + 12'h001) else $error("counter did not advance");
  fetch_addr_a: assert property (phase == PH_1 && op_q == OP_FETCH && ext_sel // RULE_09
    |=> o_bus == pc[7:0] && !o_bus_oe_n && o_port_two[3:0] == pc[11:8])
    else $error("external fetch address not on pins");
  strobe_only_a: assert property (!o_fetch_strobe_n |-> op_q == OP_FETCH // RULE_11
    && ext_q && phase inside {PH_4, PH_5, PH_6})
    else $error("fetch strobe outside an external fetch");
  ale_once_a: assert property ($rose(o_ale) |=> !o_ale [*5]) // RULE_12
    else $error("address latch pulsed twice in one cycle");
  read_strobe_a: assert property ($fell(o_rd_n) |-> // RULE_13
    ((op_q == OP_XRD || op_q == OP_BRD) && !o_rd_n) [*3] ##1 o_rd_n)
    else $error("read strobe shape wrong");
  write_data_a: assert property (!o_wr_n |-> !o_bus_oe_n && o_bus == data_q) // RULE_14
    else $error("write strobe without data on bus");
  step_halt_a: assert property (phase == PH_6 && hold // RULE_16
    |=> phase == PH_HALT && !o_ale && !o_op_ready)
    else $error("single step did not halt");
  stack_wrap_a: assert property (phase == PH_6 && op_q == OP_CALL // RULE_23
    |=> sp == $past(sp) + 3'h1) else $error("stack pointer did not wrap");

  cover property (phase == PH_4 && !o_fetch_strobe_n);
  cover property (irq_go && irq_ext);
  cover property (phase == PH_HALT ##1 phase == PH_6);
  cover property (phase == PH_6 && op_q == OP_CALL && sp == 3'h7);
endmodule : mpi_core
`default_nettype wire

// ### core/mpi_ram.sv
// module: resident data RAM, write on clock, combinational read
`timescale 1ns/10ps
`default_nettype none
module mpi_ram #(
  parameter int DEPTH = 64
) (
  input  wire logic i_clk,
  mpi_ram_if.ram    bus
);
  localparam int AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];

  // contents survive reset, as the standby RAM must
  always_ff @(posedge i_clk) begin
    if (bus.we) begin
      mem[bus.addr[AW-1:0]] <= bus.wdata;
    end
  end

  assign bus.rdata = mem[bus.addr[AW-1:0]];
endmodule : mpi_ram
`default_nettype wire

// ### core/mpi_sync.sv
// module: two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module mpi_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      meta <= RST;
      o_q  <= RST;
    end else begin
      meta <= i_d;
      o_q  <= meta;
    end
  end
endmodule : mpi_sync
`default_nettype wire

// ### pkg/mpi_pkg.sv
// package: constants and types for the microcontroller pin and memory block
// Function
// [RULE_01] reset makes the first fetched instruction come from address 0000.
// [RULE_02] low interrupt pin starts interrupt only when enabled; reset disables.
// [RULE_03] accepted external interrupt forces a call to address 0003.
// [RULE_04] enabled timer overflow forces a call to address 0007.
// [RULE_05] external access high sends every program fetch to external memory.
// [RULE_06] program counter is 12 bits wide, addressing at most 4K bytes.
// [RULE_07] fetches above internal ROM size go to external memory automatically.
// [RULE_08] each instruction cycle loads the counter: next count unless transfer.
// [RULE_09] external fetch puts low 8 counter bits on bus; memory answers.
// [RULE_10] external fetch puts high four counter bits on port two low lines.
// [RULE_11] fetch strobe goes low only during external program fetches.
// [RULE_12] address latch pulses once per machine cycle; falling edge latches.
// [RULE_13] read strobe goes low for bus reads and external data reads.
// [RULE_14] write strobe goes low for bus writes and external data writes.
// [RULE_15] external data access puts address, then data, on the bus.
// [RULE_16] single-step input with address latch halts and steps instructions.
// [RULE_17] test input zero readable by branches; can become a clock output.
// [RULE_18] test input one readable by branches; start-count makes it count source.
// [RULE_19] pointer registers are RAM locations 000 and 001 of active bank.
// [RULE_20] working registers map to RAM 0-7 in bank 0, 24-31 in bank 1.
// [RULE_21] return stack sits in RAM 8-23, two bytes per entry, 3-bit pointer.
// [RULE_22] ports one and two are quasi-bidirectional; port two drives expander.
// [RULE_23] stack pointer wraps modulo eight, overwriting the oldest entry.
package mpi_pkg;
  localparam int          PC_W        = 12;
  localparam logic [11:0] RESET_VEC   = 12'h000;
  localparam logic [11:0] EXT_IRQ_VEC = 12'h003;
  localparam logic [11:0] TMR_IRQ_VEC = 12'h007;
  localparam logic [7:0]  BANK0_BASE  = 8'h00;
  localparam logic [7:0]  BANK1_BASE  = 8'h18;
  localparam logic [7:0]  STACK_BASE  = 8'h08;
  localparam logic [7:0]  PORT_RST    = 8'hff;
  localparam int          SYNC_W      = 29;
  localparam int          SY_INT      = 28;
  localparam int          SY_SS       = 27;
  localparam int          SY_EA       = 26;
  localparam int          SY_T0       = 25;
  localparam int          SY_T1       = 24;
  localparam int          SY_BUS      = 16;
  localparam int          SY_P1       = 8;
  localparam int          SY_P2       = 0;
  localparam logic [SYNC_W-1:0] SYNC_RST = 29'h1800ffff;

  typedef enum logic [4:0] {
    OP_NONE, OP_FETCH, OP_JUMP, OP_CALL, OP_RET, OP_RETR,
    OP_XRD, OP_XWR, OP_BRD, OP_BWR, OP_EXP_RD, OP_EXP_WR,
    OP_REG_RD, OP_REG_WR, OP_IND_RD, OP_IND_WR,
    OP_P1RD, OP_P1WR, OP_P2RD, OP_P2WR,
    OP_SEL_RB0, OP_SEL_RB1, OP_EN_IRQ, OP_DIS_IRQ,
    OP_EN_TIRQ, OP_DIS_TIRQ, OP_CLK_OUT, OP_START_CNT, OP_STOP_CNT
  } mpi_op_t;

  typedef enum logic [2:0] {
    PH_1, PH_2, PH_3, PH_4, PH_5, PH_6, PH_HALT
  } mpi_phase_t;
endpackage : mpi_pkg

// ### pkg/mpi_ram_if.sv
// interface: resident RAM access between the sequencer and the RAM array
`timescale 1ns/10ps
`default_nettype none
interface mpi_ram_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       we;
  logic [7:0] rdata;
  modport master (output addr, output wdata, output we, input rdata);
  modport ram    (input addr, input wdata, input we, output rdata);
endinterface : mpi_ram_if
`default_nettype wire

// ### tb/mcu_memory_and_pin_interface_test.sv
// bench: pin-level scenarios for the microcontroller core
`timescale 1ns/10ps
`default_nettype none
module mcu_memory_and_pin_interface_test;
  import mpi_pkg::*;
  logic        i_sys_clk = 1'b0, i_reset_n = 1'b0, i_op_valid = 1'b0;
  logic        i_op_first = 1'b0, i_timer_ovf = 1'b0, i_int_n = 1'b1;
  logic        i_ss_n = 1'b1, i_ea = 1'b0, i_t1 = 1'b0, zero_pin = 1'b0;
  mpi_op_t     i_op = OP_NONE;
  logic [11:0] i_op_addr = 12'h000;
  logic [7:0]  i_op_data = 8'h00;
  logic [2:0]  i_op_reg = 3'h0;
  logic        o_op_ready, o_rdata_valid, o_irq_taken, o_count_pulse;
  logic        o_count_en, o_test_zero, o_test_one, o_irq_pin_low, o_bank1;
  logic        o_halted, o_t0, o_t0_oe_n, o_bus_oe_n, o_ale, o_rd_n, o_wr_n;
  logic        o_fetch_strobe_n, o_expander_strobe, i_t0;
  logic [7:0]  o_rdata, i_rom_data, i_bus, o_bus, i_port_one, o_port_one;
  logic [7:0]  o_port_one_oe_n, i_port_two, o_port_two, o_port_two_oe_n;
  logic [11:0] o_pc, o_rom_addr;
  int          n_errors = 0, checked = 0, cyc = 0, n_ale = 0, n_irq = 0;
  logic        fs_seen = 1'b0;
  logic [7:0]  v;

  // released quasi lines float high through their pull-ups
  assign i_port_one = o_port_one | o_port_one_oe_n;
  assign i_port_two = o_port_two | o_port_two_oe_n;
  assign i_t0 = o_t0_oe_n ? zero_pin : o_t0;
  assign i_rom_data = ~o_rom_addr[7:0];

  mpi_core #(.ROM_BYTES(1024), .RAM_BYTES(64)) uut (.*);
  mpi_ext_mem mem (.i_clk(i_sys_clk), .i_ale(o_ale),
    .i_fetch_strobe_n(o_fetch_strobe_n), .i_bus_oe_n(o_bus_oe_n),
    .i_bus_dev(o_bus), .i_addr_hi(i_port_two[3:0]), .o_bus(i_bus));

  initial forever #50 i_sys_clk = ~i_sys_clk;
  always @(posedge o_ale) n_ale++;
  always @(posedge o_irq_taken) n_irq++;
  always @(negedge o_fetch_strobe_n) fs_seen = 1'b1;
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] ext_byte(input logic [11:0] a);
    return a[7:0] ^ {a[11:8], a[11:8]};
  endfunction : ext_byte

  task automatic chk(input string what, input logic [11:0] exp,
                     input logic [11:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic req(input mpi_op_t c, input logic [11:0] a,
                     input logic [7:0] d, input logic [2:0] r);
    int n;
    n = 0;
    @(negedge i_sys_clk);
    i_op_valid = 1'b1;
    i_op = c;
    i_op_first = (c == OP_FETCH);
    i_op_addr = a;
    i_op_data = d;
    i_op_reg = r;
    while (o_op_ready !== 1'b1 && n < 40) begin
      @(negedge i_sys_clk);
      n++;
    end
    @(negedge i_sys_clk);
    i_op_valid = 1'b0;
  endtask : req

  task automatic res;
    int n;
    n = 0;
    while (o_rdata_valid !== 1'b1 && n < 20) begin
      @(negedge i_sys_clk);
      n++;
    end
    chk("result valid", 12'h001, {11'h000, o_rdata_valid});
    v = o_rdata;
  endtask : res

  task automatic fetch(input logic [11:0] at, input logic x,
                       input logic [7:0] exp);
    req(OP_JUMP, at, 8'h00, 3'h0);
    fs_seen = 1'b0;
    req(OP_FETCH, 12'h000, 8'h00, 3'h0);
    res();
    chk("fetched byte", {4'h0, exp}, {4'h0, v});
    chk("fetch strobe", {11'h000, x}, {11'h000, fs_seen});
    chk("next pc", at + 12'h001, o_pc);
  endtask : fetch
  //////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk("pc after reset", 12'h000, o_pc);
    i_int_n = 1'b0;
    req(OP_FETCH, 12'h000, 8'h00, 3'h0);
    res();
    chk("first byte", 12'h0ff, {4'h0, v});
    chk("irq after reset", 12'h000, n_irq[11:0]);
    i_int_n = 1'b1;
  endtask : t_reset

  task automatic t_fetch;
    i_ea = 1'b1;
    fetch(12'h010, 1'b1, ext_byte(12'h010));
    i_ea = 1'b0;
    fetch(12'h010, 1'b0, 8'hef);
    fetch(12'h3ff, 1'b0, 8'h00);
    fetch(12'h400, 1'b1, ext_byte(12'h400));
    fetch(12'hffe, 1'b1, ext_byte(12'hffe));
  endtask : t_fetch

  task automatic t_irq;
    req(OP_EN_TIRQ, 12'h000, 8'h00, 3'h0);
    // the enable lands at the end of its own machine cycle
    repeat (6) @(negedge i_sys_clk);
    i_timer_ovf = 1'b1;
    @(negedge i_sys_clk);
    i_timer_ovf = 1'b0;
    req(OP_FETCH, 12'h000, 8'h00, 3'h0);
    repeat (6) @(negedge i_sys_clk);
    chk("timer vector", 12'h007, o_pc);
    req(OP_RETR, 12'h000, 8'h00, 3'h0);
    req(OP_EN_IRQ, 12'h000, 8'h00, 3'h0);
    i_int_n = 1'b0;
    repeat (6) @(negedge i_sys_clk);
    req(OP_FETCH, 12'h000, 8'h00, 3'h0);
    repeat (6) @(negedge i_sys_clk);
    chk("pin vector", 12'h003, o_pc);
    chk("irq count", 12'h002, n_irq[11:0]);
    i_int_n = 1'b1;
    req(OP_RETR, 12'h000, 8'h00, 3'h0);
  endtask : t_irq

  task automatic t_ram;
    req(OP_SEL_RB1, 12'h000, 8'h00, 3'h0);
    req(OP_REG_WR, 12'h000, 8'h2a, 3'h0);
    chk("bank one", 12'h001, {11'h000, o_bank1});
    req(OP_SEL_RB0, 12'h000, 8'h00, 3'h0);
    req(OP_REG_WR, 12'h000, BANK1_BASE, 3'h0);
    req(OP_IND_RD, 12'h000, 8'h00, 3'h0);
    res();
    chk("indirect read", 12'h02a, {4'h0, v});
  endtask : t_ram

  task automatic t_pins;
    @(negedge i_sys_clk);
    n_ale = 0;
    repeat (12) @(negedge i_sys_clk);
    chk("latch pulses", 12'h002, n_ale[11:0]);
    i_t1 = 1'b1;
    zero_pin = 1'b1;
    repeat (3) @(negedge i_sys_clk);
    chk("test one", 12'h001, {11'h000, o_test_one});
    chk("test zero", 12'h001, {11'h000, o_test_zero});
  endtask : t_pins

  task automatic close_out;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : close_out

  initial begin
    repeat (6) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    t_reset();
    t_fetch();
    t_irq();
    t_ram();
    t_pins();
    close_out();
  end
endmodule : mcu_memory_and_pin_interface_test
`default_nettype wire

// ### tb/mpi_ext_mem.sv
// model: external program memory answering fetches on the multiplexed bus
`timescale 1ns/10ps
`default_nettype none
module mpi_ext_mem (
  input  wire logic       i_clk,
  input  wire logic       i_ale,
  input  wire logic       i_fetch_strobe_n,
  input  wire logic       i_bus_oe_n,
  input  wire logic [7:0] i_bus_dev,
  input  wire logic [3:0] i_addr_hi,
  output logic      [7:0] o_bus
);
  logic [11:0] addr = 12'h000;
  logic [7:0]  last = 8'h00;
  // address is taken on the falling edge of the latch pulse
  always @(negedge i_ale) addr = {i_addr_hi, i_bus_dev};
  // a floating bus must not hold its old value, so it toggles each cycle
  always @(posedge i_clk) last <= o_bus;
  always_comb begin
    if (!i_bus_oe_n)
      o_bus = i_bus_dev;
    else if (!i_fetch_strobe_n)
      o_bus = addr[7:0] ^ {addr[11:8], addr[11:8]};
    else
      o_bus = ~last;
  end
endmodule : mpi_ext_mem
`default_nettype wire
